// ---- core/fdpr_pkg.sv ----
// fdpr_pkg: constants and types of the floppy data port and rate registers.
// assumes a 32-bit AHB-Lite slave; registers live at word index times four.
package fdpr_pkg;

   // register indices as printed, byte address is four times the index
   localparam logic [9:0]  IDX_MAIN_STATUS  = 10'h3F4;
   localparam logic [9:0]  IDX_DATA_PORT    = 10'h3F5;
   localparam logic [9:0]  IDX_XFER_STATUS  = 10'h3F6;
   localparam logic [9:0]  IDX_DIGITAL_IN   = 10'h3F7;
   localparam logic [11:0] ADDR_MAIN_STATUS = {IDX_MAIN_STATUS, 2'b00};
   localparam logic [11:0] ADDR_DATA_PORT   = {IDX_DATA_PORT, 2'b00};
   localparam logic [11:0] ADDR_XFER_STATUS = {IDX_XFER_STATUS, 2'b00};
   localparam logic [11:0] ADDR_DIGITAL_IN  = {IDX_DIGITAL_IN, 2'b00};
   localparam int          ADDR_MSB         = 11;

   // main status register fields
   localparam int MSR_READY_BIT = 7;
   localparam int MSR_DIR_BIT   = 6;
   localparam int MSR_EXEC_BIT  = 5;
   localparam int MSR_BUSY_BIT  = 4;

   // transfer status register fields
   localparam int XS_ERR_BIT    = 0;
   localparam int XS_FIFO_BIT   = 1;
   localparam int XS_DRAIN_BIT  = 2;
   localparam int XS_COUNT_LSB  = 4;

   // digital input register fields
   localparam int DI_MEDIA_BIT  = 7;
   localparam int DI2_DENS_BIT  = 0;
   localparam int DI2_RATE_LSB  = 1;
   localparam int DI2_ONES_LSB  = 3;
   localparam int DI3_RATE_LSB  = 0;
   localparam int DI3_SKIP_BIT  = 2;
   localparam int DI3_DMA_BIT   = 3;

   // configuration control register fields
   localparam int CCR_RATE_LSB  = 0;
   localparam int CCR_SKIP_BIT  = 2;

   // rate select codes
   localparam logic [1:0] RATE_500   = 2'h0;
   localparam logic [1:0] RATE_300   = 2'h1;
   localparam logic [1:0] RATE_250   = 2'h2;
   localparam logic [1:0] RATE_1M    = 2'h3;
   localparam logic [1:0] RATE_RESET = RATE_250;

   // register modes on the static mode pins
   localparam logic [1:0] MODE_FIRST  = 2'h0;
   localparam logic [1:0] MODE_SECOND = 2'h1;
   localparam logic [1:0] MODE_THIRD  = 2'h2;

   // data buffer geometry and fill pattern
   localparam int          FIFO_DEPTH = 16;
   localparam int          PTR_W      = 4;
   localparam int          CNT_W      = 5;
   localparam logic [7:0]  FILL_BYTE  = 8'h00;
   localparam logic [3:0]  THR_RESET  = 4'h1;

   // sequencer phase of the current command
   typedef enum logic [1:0] {PH_IDLE, PH_COMMAND, PH_EXEC, PH_RESULT}
      fdpr_phase_e;

   // one byte on the sequencer side
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } fdpr_byte_s;

endpackage

// ---- core/fdpr_regs.sv ----
// fdpr_regs: host data port, digital input and rate control registers.
// assumes a single AHB-Lite master and a command sequencer on clk.
// Behaviour
// - One read/write byte port carries command, data and result bytes.
// - Port transfers are paced by the ready and direction status bits.
// - Any reset leaves the buffer disabled; configure turns it on.
// - Buffer action is off at command start; parameters go singly.
// - Entering execution flushes every byte held in the buffer.
// - Late host service causing overrun or underrun stops the command.
// - Underrun on a disk write pads the sector with zero bytes.
// - Digital input register is read-only; writes reach rate control.
// - First mode drives only bit 7 of the digital input register.
// - Bit 7 shows the inverted media pin or a forced value.
// - Second mode bit 0 low at 500K or 1M, high at 250K or 300K.
// - Second mode bits 1-2 give rate, bits 3-6 read one.
// - Rate survives soft reset; hard reset sets the 250K code.
// - Third mode bit 2 returns the stored skip-compensation bit.
// - Third mode bit 3 gives the DMA gate, bits 4-6 read zero.
// - First and second modes: rate control write loads bits 0-1 only.
// - Third mode stores bit 2 inertly; soft reset keeps it.
// - Density pin goes high on hard reset; soft resets leave it.
// - Effective rate is the latest write of either rate register.
// - Ready bit is one only when a port transfer is allowed.
// - Direction bit is one for host read, zero for host write.
//
// Chosen here: the AHB-Lite slave port.

`timescale 1ns/100ps
`default_nettype none

module fdpr_regs
   import fdpr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // command sequencer
   input  wire fdpr_phase_e seqPhase,
   input  wire logic        seqDiskRead,
   input  wire logic        swReset,
   input  wire logic        cfgLoad,
   input  wire logic        cfgFifoOn,
   input  wire logic [3:0]  cfgThreshold,
   input  wire fdpr_byte_s  coreIn,
   input  wire logic        corePull,
   output fdpr_byte_s       coreOut,
   output logic             xferStop,
   output logic             xferErr,
   output logic             drainDone,
   // neighbouring registers
   input  wire logic        dmaGate,
   input  wire logic        dsrRateWe,
   input  wire logic [1:0]  dsrRate,
   input  wire logic        forceMediaEn,
   input  wire logic        forceMediaVal,
   // drive cable and straps
   input  wire logic        mediaChangedPin,
   input  wire logic [1:0]  regModePin,
   output logic             densityPin,
   // status toward the rest of the controller
   output logic             hostRequestReady,
   output logic             transferDirection,
   output logic      [1:0]  rateSelect,
   output logic             skipWriteComp
);

   logic [7:0]       mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wrPtr;
   logic [PTR_W-1:0] rdPtr;
   logic [CNT_W-1:0] count;
   logic             fifoOn;
   logic [3:0]       threshold;
   fdpr_phase_e      prevPhase;
   logic             mediaMeta;
   logic             mediaSync;
   logic [1:0]       modeMeta;
   logic [1:0]       regMode;
   logic             dpValid;
   logic             dpWrite;
   logic [11:0]      dpAddr;

   logic             dirRead;
   logic             fifoAct;
   logic [CNT_W-1:0] limit;
   logic             fullNow;
   logic             readyNow;
   logic             addrAccept;
   logic             hostPop;
   logic             hostPush;
   logic             corePushOk;
   logic             corePullOk;
   logic             pushEn;
   logic             popEn;
   logic             overrun;
   logic             underrun;
   logic             flush;
   logic             cmdStart;
   logic             ccrWrite;
   logic [7:0]       pushByte;
   logic [7:0]       dirValue;
   logic [7:0]       msrValue;
   logic [31:0]      xsValue;
   logic [31:0]      readMux;

   // pins from the cable and straps: two flops before any use
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mediaMeta <= 1'b0;
         mediaSync <= 1'b0;
         modeMeta  <= MODE_FIRST;
         regMode   <= MODE_FIRST;
      end else begin
         mediaMeta <= mediaChangedPin;
         mediaSync <= mediaMeta;
         modeMeta  <= regModePin;
         regMode   <= modeMeta;
      end
   end

   // direction and pacing; buffering only acts during execution
   always_comb begin
      dirRead = (seqPhase == PH_RESULT) ||
                ((seqPhase == PH_EXEC) && seqDiskRead);
      fifoAct = fifoOn && (seqPhase == PH_EXEC);
      limit   = fifoAct ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
      fullNow = (count >= limit);
      if (dirRead) begin
         // partial bursts become visible once an error ends the transfer
         readyNow = (count != '0) &&
                    (!fifoAct || (count >= {1'b0, threshold}) ||
                     xferErr);
      end else begin
         readyNow = !fullNow &&
                    !(xferErr && (seqPhase == PH_EXEC));
      end
   end

   // bus handshake decode
   always_comb begin
      addrAccept = hsel && htrans[1] && hready;
      hostPop    = addrAccept && !hwrite &&
                   (haddr[ADDR_MSB:0] == ADDR_DATA_PORT) &&
                   readyNow && dirRead;
      hostPush   = dpValid && dpWrite && (dpAddr == ADDR_DATA_PORT) &&
                   readyNow && !dirRead;
      ccrWrite   = dpValid && dpWrite &&
                   (dpAddr == ADDR_DIGITAL_IN);
   end

   // sequencer side of the buffer and error detection
   always_comb begin
      corePushOk = coreIn.valid && dirRead && !fullNow &&
                   !(xferErr && (seqPhase == PH_EXEC));
      corePullOk = corePull && !dirRead && (count != '0) && !xferErr;
      overrun    = coreIn.valid && dirRead && fullNow &&
                   (seqPhase == PH_EXEC) && !xferErr;
      underrun   = corePull && !dirRead && (count == '0) &&
                   (seqPhase == PH_EXEC) && !xferErr;
      pushEn     = dirRead ? corePushOk : hostPush;
      popEn      = dirRead ? hostPop : corePullOk;
      pushByte   = dirRead ? coreIn.data : hwdata[7:0];
      cmdStart   = (seqPhase == PH_COMMAND) && (prevPhase != PH_COMMAND);
      flush      = swReset ||
                   ((seqPhase == PH_EXEC) && (prevPhase != PH_EXEC));
   end

   // phase history for edge detection of command and execution entry
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prevPhase <= PH_IDLE;
      end else begin
         prevPhase <= seqPhase;
      end
   end

   // buffer storage: a write port only, no reset needed on data
   always_ff @(posedge clk) begin
      if (pushEn && !flush) begin
         mem[wrPtr] <= pushByte;
      end
   end

   // buffer pointers and fill level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else if (flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (pushEn) begin
            wrPtr <= wrPtr + PTR_W'(1);
         end
         if (popEn) begin
            rdPtr <= rdPtr + PTR_W'(1);
         end
         count <= count + CNT_W'(pushEn) - CNT_W'(popEn);
      end
   end

   // buffer mode from the configure command; any reset disables it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fifoOn    <= 1'b0;
         threshold <= THR_RESET;
      end else if (swReset) begin
         fifoOn    <= 1'b0;
         threshold <= THR_RESET;
      end else if (cfgLoad) begin
         fifoOn    <= cfgFifoOn;
         // a zero threshold is replaced by the reset threshold THR_RESET
         threshold <= (cfgThreshold == '0) ? THR_RESET : cfgThreshold;
      end
   end

   // sticky transfer error; a new error beats the clear at command start
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xferErr  <= 1'b0;
         xferStop <= 1'b0;
      end else begin
         xferStop <= overrun || underrun;
         if (overrun || underrun) begin
            xferErr <= 1'b1;
         end else if (swReset || cmdStart) begin
            xferErr <= 1'b0;
         end
      end
   end

   // bytes toward the sequencer; after underrun only zero fill goes out
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         coreOut <= '0;
      end else begin
         coreOut.valid <= corePull;
         if (corePullOk) begin
            coreOut.data <= mem[rdPtr];
         end else begin
            coreOut.data <= FILL_BYTE;
         end
      end
   end

   // empty flag lets the sequencer hold off the result phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drainDone <= 1'b1;
      end else begin
         drainDone <= (count == '0) && !pushEn;
      end
   end

   // status bits registered for the pins and the status register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hostRequestReady  <= 1'b0;
         transferDirection <= 1'b0;
      end else begin
         hostRequestReady  <= readyNow;
         transferDirection <= dirRead;
      end
   end

   // rate select: latest write of either register wins, soft reset inert
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rateSelect <= RATE_RESET;
      end else if (ccrWrite) begin
         rateSelect <= hwdata[CCR_RATE_LSB +: 2];
      end else if (dsrRateWe) begin
         rateSelect <= dsrRate;
      end
   end

   // skip-compensation bit: stored only, no effect on write timing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         skipWriteComp <= 1'b0;
      end else if (ccrWrite && (regMode == MODE_THIRD)) begin
         skipWriteComp <= hwdata[CCR_SKIP_BIT];
      end
   end

   // density pin follows the rate; only the hard reset forces it high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         densityPin <= 1'b1;
      end else begin
         densityPin <= (rateSelect == RATE_500) || (rateSelect == RATE_1M);
      end
   end

   // digital input register layout per register mode
   always_comb begin
      dirValue = '0;
      dirValue[DI_MEDIA_BIT] = forceMediaEn ? forceMediaVal
                                            : !mediaSync;
      unique case (regMode)
         MODE_SECOND: begin
            dirValue[DI2_DENS_BIT] = (rateSelect == RATE_250) ||
                                     (rateSelect == RATE_300);
            dirValue[DI2_RATE_LSB +: 2] = rateSelect;
            dirValue[DI2_ONES_LSB +: 4] = 4'hF;
         end
         MODE_THIRD: begin
            dirValue[DI3_RATE_LSB +: 2] = rateSelect;
            dirValue[DI3_SKIP_BIT] = skipWriteComp;
            dirValue[DI3_DMA_BIT]  = dmaGate;
         end
         default: begin
            // low bits are undriven on the pin bus; here they read zero
            dirValue[DI_MEDIA_BIT - 1:0] = '0;
         end
      endcase
   end

   // main and transfer status images
   always_comb begin
      msrValue = '0;
      msrValue[MSR_READY_BIT] = hostRequestReady;
      msrValue[MSR_DIR_BIT]   = transferDirection;
      msrValue[MSR_EXEC_BIT]  = (seqPhase == PH_EXEC);
      msrValue[MSR_BUSY_BIT]  = (seqPhase != PH_IDLE);
      xsValue = '0;
      xsValue[XS_ERR_BIT]   = xferErr;
      xsValue[XS_FIFO_BIT]  = fifoOn;
      xsValue[XS_DRAIN_BIT] = drainDone;
      xsValue[XS_COUNT_LSB +: CNT_W] = count;
   end

   // read data selected at the address phase; the data port pops here
   always_comb begin
      readMux = '0;
      unique case (haddr[ADDR_MSB:0])
         ADDR_MAIN_STATUS: readMux = {24'h000000, msrValue};
         ADDR_DATA_PORT:   readMux = hostPop ? {24'h000000, mem[rdPtr]}
                                             : '0;
         ADDR_XFER_STATUS: readMux = xsValue;
         ADDR_DIGITAL_IN:  readMux = {24'h000000, dirValue};
         default:          readMux = '0;
      endcase
   end

   // ahb-lite slave: zero wait states, always OKAY
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dpValid   <= 1'b0;
         dpWrite   <= 1'b0;
         dpAddr    <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dpValid   <= addrAccept;
         dpWrite   <= addrAccept && hwrite;
         dpAddr    <= haddr[ADDR_MSB:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addrAccept && !hwrite) begin
            hrdata <= readMux;
         end
      end
   end

endmodule

`default_nettype wire

// ---- sim/fdpr_regs_monitor.sv ----
// fdpr_regs_monitor: concurrent checks on the register block's ports.
// assumes binding into fdpr_regs; one clock domain, async low reset.
`timescale 1ns/100ps
`default_nettype none

module fdpr_regs_monitor
   import fdpr_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // sequencer side
   input wire fdpr_phase_e seqPhase,
   input wire logic        seqDiskRead,
   input wire logic        corePull,
   input wire fdpr_byte_s  coreOut,
   input wire logic        xferStop,
   input wire logic        xferErr,
   input wire logic        drainDone,
   // status and pins
   input wire logic        densityPin,
   input wire logic        hostRequestReady,
   input wire logic        transferDirection,
   input wire logic [1:0]  rateSelect,
   input wire logic        skipWriteComp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // pull of an empty write buffer while no error is pending
   sequence s_underrun;
      corePull && seqPhase == PH_EXEC && !seqDiskRead && drainDone && !xferErr;
   endsequence
   // zero fill handed back, with the stop pulse in that cycle or the next
   sequence s_fill_stop;
      coreOut.valid && coreOut.data == FILL_BYTE ##[0:1] xferStop;
   endsequence
   sequence s_enter_exec;
      $changed(seqPhase) && seqPhase == PH_EXEC;
   endsequence

   property p_hw_rate;
      $rose(nrst) |-> rateSelect == RATE_RESET && !skipWriteComp;
   endproperty
   // density lags the rate by at most one cycle, hence the stable guard
   property p_density;
      $past(nrst) && $stable(rateSelect) |->
         densityPin == !(rateSelect[0] ^ rateSelect[1]);
   endproperty
   property p_pull;
      corePull |=> coreOut.valid;
   endproperty
   property p_flush;
      s_enter_exec |-> ##[1:2] drainDone;
   endproperty
   property p_underrun;
      s_underrun |=> s_fill_stop;
   endproperty
   property p_stop;
      xferStop |=> !xferStop && xferErr;
   endproperty
   property p_idle;
      $past(nrst) && seqPhase == PH_IDLE && $past(seqPhase) == PH_IDLE
         |-> hostRequestReady && !transferDirection;
   endproperty
   property p_dir;
      $past(nrst) && seqPhase == PH_EXEC && $past(seqPhase) == PH_EXEC &&
         seqDiskRead && $past(seqDiskRead) && hostRequestReady
         |-> transferDirection;
   endproperty
   property p_err_clear;
      $changed(seqPhase) && seqPhase == PH_COMMAND |-> ##[1:2] !xferErr;
   endproperty

   a_hw_rate: assert property (p_hw_rate)
      else $error("rate not at reset code");
   a_density: assert property (p_density)
      else $error("density pin disagrees with rate");
   a_pull: assert property (p_pull)
      else $error("pull not answered");
   a_flush: assert property (p_flush)
      else $error("buffer not flushed on execution");
   a_underrun: assert property (p_underrun)
      else $error("underrun not filled and stopped");
   a_stop: assert property (p_stop)
      else $error("stop pulse wrong");
   a_idle: assert property (p_idle)
      else $error("idle status wrong");
   a_dir: assert property (p_dir)
      else $error("read direction not shown");
   a_err_clear: assert property (p_err_clear)
      else $error("error flag kept at command start");
endmodule

`default_nettype wire

// ---- sim/fdpr_seq_model.sv ----
// fdpr_seq_model: far-side byte mover feeding and draining the data port.
// assumes the bench calls push and pull; gap slows every transfer.
`timescale 1ns/100ps
`default_nettype none

module fdpr_seq_model
   import fdpr_pkg::*;
(
   // clock
   input  wire logic       clk,
   // byte path
   output var fdpr_byte_s  coreIn,
   output var logic        corePull,
   input  wire fdpr_byte_s coreOut
);
   int gap = 0; // idle cycles before each transfer

   initial begin
      coreIn = '0;
      corePull = 1'b0;
   end

   // one byte at a time, strobe held for exactly one edge
   task automatic push(input logic [7:0] b);
      repeat (gap) @(posedge clk);
      @(posedge clk) coreIn <= '{1'b1, b};
      @(posedge clk) coreIn <= '0;
   endtask

   // answer lands one cycle after the pull edge
   task automatic pull(output logic [7:0] b);
      repeat (gap) @(posedge clk);
      @(posedge clk) corePull <= 1'b1;
      @(posedge clk) corePull <= 1'b0;
      #1 b = coreOut.data;
   endtask
endmodule

`default_nettype wire

// ---- sim/floppy_data_port_and_rate_regs_tb.sv ----
// floppy_data_port_and_rate_regs_tb: self-checking bench for fdpr_regs.
// assumes an AHB-Lite master here and the sequencer model beside it.
`timescale 1ns/100ps
`default_nettype none

module floppy_data_port_and_rate_regs_tb;
   import fdpr_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0]  htrans = 2'h0, dsrRate = 2'h0, regModePin = 2'h0, rateSelect;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, hready, corePull, xferStop, xferErr;
   fdpr_phase_e seqPhase = PH_IDLE;
   logic        seqDiskRead = 1'b0, swReset = 1'b0, cfgLoad = 1'b0;
   logic        cfgFifoOn = 1'b0, dmaGate = 1'b0, dsrRateWe = 1'b0;
   logic        forceMediaEn = 1'b0, forceMediaVal = 1'b0, drainDone;
   logic        mediaChangedPin = 1'b0, densityPin, skipWriteComp;
   logic        hostRequestReady, transferDirection;
   logic [3:0]  cfgThreshold = 4'h0;
   fdpr_byte_s  coreIn, coreOut;
   int          num_errors = 0, n_compared = 0;

   assign hready = hreadyout;
   always #2 clk = ~clk;

   fdpr_regs dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .seqPhase, .seqDiskRead,
      .swReset, .cfgLoad, .cfgFifoOn, .cfgThreshold, .coreIn, .corePull,
      .coreOut, .xferStop, .xferErr, .drainDone, .dmaGate, .dsrRateWe,
      .dsrRate, .forceMediaEn, .forceMediaVal, .mediaChangedPin, .regModePin,
      .densityPin, .hostRequestReady, .transferDirection, .rateSelect,
      .skipWriteComp);
   fdpr_seq_model seq (.clk, .coreIn, .corePull, .coreOut);

   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // single word transfer; hready is judged at the edge itself, before the
   // slave's registers move, and only the watchdog ends a stuck wait
   task automatic ahb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= wr;
      @(posedge clk iff hready === 1'b1);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= {24'h0, d};
      @(posedge clk iff hready === 1'b1);
      q = hrdata[7:0];
      cmp8({7'h0, hresp}, 8'h00);
   endtask

   // status is registered, so let it settle before each poll
   task automatic wait_rdy(input logic dir);
      logic [7:0] s;
      int n;
      s = 8'h00;
      n = 0;
      while (!(s[MSR_READY_BIT] && s[MSR_DIR_BIT] == dir) && n < 50) begin
         repeat (2) @(posedge clk);
         ahb(1'b0, ADDR_MAIN_STATUS, 8'h00, s);
         n++;
      end
      cmp8({6'h0, s[7:6]}, {6'h0, 1'b1, dir});
   endtask

   function automatic logic [7:0] exp_dir(input logic [1:0] m, r,
                                          input logic k, b7, g);
      case (m)
         MODE_SECOND: return {b7, 4'hF, r, r[0] ^ r[1]};
         MODE_THIRD:  return {b7, 3'h0, g, k, r};
         default:     return {b7, 7'h00};
      endcase
   endfunction

   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      logic [7:0] q, d, b[$];
      logic [1:0] r, m;
      logic       k;
      void'($urandom(85861));
      k = 1'b0;
      repeat (2) @(posedge clk);
      cmp8({7'h0, densityPin}, 8'h01);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      cmp8({6'h0, rateSelect}, {6'h0, RATE_RESET});
      // every layout, with a rate-select write ahead of the control write
      for (int i = 0; i < 9; i++) begin
         m = 2'(i % 3);
         r = 2'($urandom);
         if (m == MODE_THIRD) k = 1'($urandom);
         regModePin <= m; mediaChangedPin <= 1'($urandom);
         dmaGate <= 1'($urandom); forceMediaEn <= 1'($urandom);
         forceMediaVal <= 1'($urandom); dsrRateWe <= 1'b1; dsrRate <= ~r;
         @(posedge clk) dsrRateWe <= 1'b0;
         repeat (4) @(posedge clk);
         cmp8({6'h0, rateSelect}, {6'h0, ~r});
         d = {5'h0, k & m[1], r};
         ahb(1'b1, ADDR_DIGITAL_IN, d, q);
         ahb(1'b0, ADDR_DIGITAL_IN, 8'h00, q);
         d = exp_dir(m, r, k,
                     forceMediaEn ? forceMediaVal : ~mediaChangedPin,
                     dmaGate);
         cmp8(q, d);
         cmp8({5'h0, skipWriteComp, rateSelect}, {5'h0, k, r});
      end
      @(posedge clk) swReset <= 1'b1;
      @(posedge clk) swReset <= 1'b0;
      repeat (3) @(posedge clk);
      cmp8({5'h0, skipWriteComp, rateSelect}, {5'h0, k, r});
      cmp8({7'h0, densityPin}, {7'h0, ~(r[0] ^ r[1])});
      // command bytes go one by one
      seqPhase <= PH_COMMAND;
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         wait_rdy(1'b0);
         ahb(1'b1, ADDR_DATA_PORT, d, q);
         seq.pull(q);
         cmp8(q, d);
      end
      // unbuffered disk read with a slow far side
      seqPhase <= PH_EXEC; seqDiskRead <= 1'b1; seq.gap = 3;
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         seq.push(d);
         wait_rdy(1'b1);
         ahb(1'b0, ADDR_DATA_PORT, 8'h00, q);
         cmp8(q, d);
      end
      // stale command byte must vanish, then the write underruns
      seqPhase <= PH_COMMAND; seq.gap = 0;
      wait_rdy(1'b0);
      ahb(1'b1, ADDR_DATA_PORT, 8'h5A, q);
      seqPhase <= PH_EXEC; seqDiskRead <= 1'b0;
      repeat (3) @(posedge clk);
      seq.pull(q);
      cmp8(q, FILL_BYTE);
      // a result byte travels back while the error is still flagged
      seqPhase <= PH_RESULT;
      d = 8'($urandom);
      seq.push(d);
      wait_rdy(1'b1);
      ahb(1'b0, ADDR_DATA_PORT, 8'h00, q);
      cmp8(q, d);
      repeat (2) @(posedge clk);
      ahb(1'b0, ADDR_XFER_STATUS, 8'h00, q);
      cmp8({7'h0, q[XS_ERR_BIT]}, 8'h01);
      // buffered read overrun, host then drains what is left
      seqPhase <= PH_COMMAND; seqDiskRead <= 1'b1;
      repeat (2) @(posedge clk);
      cfgLoad <= 1'b1; cfgFifoOn <= 1'b1; cfgThreshold <= 4'h8;
      @(posedge clk) cfgLoad <= 1'b0;
      repeat (2) @(posedge clk) seqPhase <= PH_EXEC;
      repeat (3) @(posedge clk);
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         b.push_back(8'($urandom));
         seq.push(b[i]);
      end
      repeat (3) @(posedge clk);
      ahb(1'b0, ADDR_XFER_STATUS, 8'h00, q);
      cmp8({6'h0, q[1:0]}, 8'h03);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         wait_rdy(1'b1);
         ahb(1'b0, ADDR_DATA_PORT, 8'h00, q);
         cmp8(q, b[i]);
      end
      repeat (3) @(posedge clk);
      cmp8({7'h0, drainDone}, 8'h01);
      @(posedge clk) swReset <= 1'b1;
      @(posedge clk) swReset <= 1'b0;
      repeat (3) @(posedge clk);
      ahb(1'b0, ADDR_XFER_STATUS, 8'h00, q);
      cmp8({6'h0, q[1:0]}, 8'h00);
      seqPhase <= PH_IDLE;
      repeat (4) @(posedge clk);
      end_of_test;
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end
endmodule

bind fdpr_regs fdpr_regs_monitor u_mon (.clk, .nrst, .seqPhase, .seqDiskRead,
   .corePull, .coreOut, .xferStop, .xferErr, .drainDone, .densityPin,
   .hostRequestReady, .transferDirection, .rateSelect, .skipWriteComp);

`default_nettype wire
